// [verilog/adc_sequence_control.sv]
// Purpose: Sequences four conversions per pass and holds the control/status and result registers.
// Assumes: Classic Wishbone slave, 20 MHz clock used as the conversion clock; low_power_i marks stop or wait.
// Notes: Each register takes one word at four times its printed offset; registered reads answer next cycle.
//
// Operation
// RQ1: Group one-shot converts each group channel once.
// RQ2: One-shot stops after fourth conversion, idle.
// RQ3: Group continuous wraps results to register one.
// RQ4: Stop or wait suspends the current conversion.
// RQ5: On resume, resample interrupted channel and continue.
// RQ6: First conversion after wait is valid.
// RQ7: Software waits 10 ms after undelayed stop.
// RQ8: Flag read-only, bit 6 zero, others writable.
// RQ9: Control write aborts and restarts the sequence.
// RQ10: Control write clears the complete flag.
// RQ11: Flag sets when all four results valid.
// RQ12: Continuous mode sets flag once, keeps it.
// RQ13: Scan off once, scan on round-robin.
// RQ14: Single mode converts one channel four times.
// RQ15: Group mode uses high select bits only.
// RQ16: Channel codes decode to inputs and references.
// RQ17: Group channel low bits pick result register.
// RQ18: Results are read-only eight-bit, writes ignored.
// RQ19: Software trusts results only with flag set.
// RQ20: Sequence begins one clock after the write.
// RQ21: Eight MSB-first steps, result stored at end.
// RQ22: Each conversion takes 32 clock cycles.
`include "converter_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module adc_sequence_control #(
    parameter int CONV_CYCLES = `CONV_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [15:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // Power modes
    input wire logic low_power_i,
    // Analog front end
    input wire logic comp_i,
    output logic [3:0] mux_sel_o,
    output logic [1:0] ref_sel_o,
    output logic sample_o,
    output logic [7:0] dac_o,
    output logic busy_o
);
    typedef struct packed {
        converter_pkg::seq_state_e state;
        logic [7:0] ctl;
        logic [1:0] slot;
        logic       filled;
        logic [31:0] rdata;
        logic       ack;
        logic       err;
        logic [3:0][7:0] result;
    } top_state_s;

    top_state_s st_reg;
    top_state_s st_next;
    converter_pkg::conv_req_s req;
    converter_pkg::conv_res_s res;
    logic [3:0] chan;
    logic hit_ctl;
    logic [3:0] hit_res;
    logic any_hit;
    logic bus_req;
    logic ctl_write;
    logic [15:0] word_adr;

    assign bus_req = cyc_i && stb_i && !st_reg.ack && !st_reg.err;
    assign word_adr = adr_i >> `ADDR_SCALE;
    assign hit_ctl = word_adr == `CTL_OFFSET && adr_i[1:0] == 2'h0;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_hit
            assign hit_res[gi] = word_adr == `RES1_OFFSET + 16'(gi) && adr_i[1:0] == 2'h0;
        end
    endgenerate

    assign any_hit = hit_ctl || (|hit_res);
    assign ctl_write = bus_req && we_i && hit_ctl && sel_i[0];

    // Single mode keeps all four select bits; group mode replaces the low two with the slot.
    always_comb begin
        if (st_reg.ctl[`CTL_GROUP_BIT]) begin
            chan = {st_reg.ctl[3:2], st_reg.slot}; // RQ15 RQ17
        end else begin
            chan = st_reg.ctl[3:0]; // RQ14
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.ack = 1'b0;
        st_next.err = 1'b0;
        req.channel = chan;
        req.start = 1'b0;
        req.abort = 1'b0;
        if (bus_req) begin
            st_next.ack = any_hit;
            st_next.err = !any_hit;
            st_next.rdata = 32'h0000_0000;
            if (hit_ctl) begin
                st_next.rdata[7:0] = {st_reg.ctl[7], 1'b0, st_reg.ctl[5:0]}; // RQ8
            end
            for (int i = 0; i < 4; i++) begin
                if (hit_res[i]) begin
                    st_next.rdata[7:0] = st_reg.result[i]; // RQ18
                end
            end
        end
        case (st_reg.state)
            converter_pkg::SEQ_IDLE: begin
            end
            converter_pkg::SEQ_START: begin
                if (low_power_i) begin
                    st_next.state = converter_pkg::SEQ_HOLD; // RQ4
                end else begin
                    req.start = 1'b1; // RQ20 RQ5 RQ6
                    st_next.state = converter_pkg::SEQ_CONVERT;
                end
            end
            converter_pkg::SEQ_CONVERT: begin
                if (low_power_i) begin
                    req.abort = 1'b1; // RQ4
                    st_next.state = converter_pkg::SEQ_HOLD;
                end else if (res.done) begin
                    st_next.result[st_reg.slot] = res.value; // RQ21 RQ1 RQ3 RQ17
                    st_next.slot = st_reg.slot + 2'h1;
                    if (st_reg.slot == 2'h3) begin
                        st_next.ctl[`CTL_FLAG_BIT] = 1'b1; // RQ11 RQ12
                        st_next.filled = 1'b1;
                        if (st_reg.ctl[`CTL_SCAN_BIT]) begin
                            st_next.state = converter_pkg::SEQ_START; // RQ3 RQ13
                        end else begin
                            st_next.state = converter_pkg::SEQ_IDLE; // RQ2 RQ13
                        end
                    end else begin
                        st_next.state = converter_pkg::SEQ_START;
                    end
                end
            end
            converter_pkg::SEQ_HOLD: begin
                // The interrupted channel is sampled again from scratch, since the held charge has drifted.
                if (!low_power_i) begin
                    st_next.state = converter_pkg::SEQ_START; // RQ5
                end
            end
            default: begin
                st_next.state = converter_pkg::SEQ_IDLE;
            end
        endcase
        // A write overrides the sequencer's state, slot and flag this cycle; a result finishing in the same cycle is still stored.
        if (ctl_write) begin
            req.abort = 1'b1; // RQ9
            st_next.ctl = (dat_i[7:0] & `CTL_WRITE_MASK); // RQ8 RQ10
            st_next.slot = 2'h0;
            st_next.filled = 1'b0;
            st_next.state = converter_pkg::SEQ_START; // RQ9 RQ20
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.state <= converter_pkg::SEQ_IDLE;
            st_reg.ctl <= `CTL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    sar_engine #(
        .CONV_CYCLES(CONV_CYCLES),
        .SAMPLE_CYCLES(`SAMPLE_CYCLES)
    ) u_sar (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .req_i(req),
        .res_o(res),
        .comp_i(comp_i),
        .mux_sel_o(mux_sel_o),
        .sample_o(sample_o),
        .dac_o(dac_o)
    );

    // Reference selection for codes 1100 to 1110; reserved codes select nothing.
    always_comb begin
        ref_sel_o = 2'h0;
        if (mux_sel_o[3:2] == `CHAN_GROUP_REF && mux_sel_o[1:0] != 2'h3) begin
            ref_sel_o = mux_sel_o[1:0] + 2'h1; // RQ16
        end
    end

    assign dat_o = st_reg.rdata;
    assign ack_o = st_reg.ack;
    assign err_o = st_reg.err;
    assign busy_o = st_reg.state != converter_pkg::SEQ_IDLE;

    a_write_clears_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        ctl_write |=> !st_reg.ctl[`CTL_FLAG_BIT] && st_reg.state == converter_pkg::SEQ_START) // RQ10
        else $error("Control write did not clear flag and restart.");
    a_bit6_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.ack && $past(hit_ctl) && !$past(we_i) |-> dat_o[6] == 1'b0) // RQ8
        else $error("Bit 6 read nonzero.");
    a_start_next_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ctl_write ##1 !low_power_i |-> req.start) // RQ20
        else $error("Sequence did not start one cycle after write.");
    a_oneshot_stops: assert property (@(posedge clk_i) disable iff (rst_i)
        res.done && st_reg.slot == 2'h3 && !st_reg.ctl[`CTL_SCAN_BIT] && !ctl_write && !low_power_i
        |=> st_reg.state == converter_pkg::SEQ_IDLE && st_reg.ctl[`CTL_FLAG_BIT]) // RQ2
        else $error("One-shot sequence did not halt with flag set.");
    a_flag_stays_set: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.ctl[`CTL_FLAG_BIT] && !ctl_write |=> st_reg.ctl[`CTL_FLAG_BIT]) // RQ12
        else $error("Complete flag dropped without a write.");
    a_suspend_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.state == converter_pkg::SEQ_CONVERT && low_power_i && !ctl_write
        |=> st_reg.state == converter_pkg::SEQ_HOLD && !res.done) // RQ4
        else $error("Conversion not suspended on low power.");
    a_resume_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.state == converter_pkg::SEQ_HOLD && !low_power_i && !ctl_write
        |=> st_reg.state == converter_pkg::SEQ_START && $stable(st_reg.slot)) // RQ5
        else $error("Sequence did not resume at the interrupted slot.");
    a_group_channel: assert property (@(posedge clk_i) disable iff (rst_i)
        req.start && st_reg.ctl[`CTL_GROUP_BIT] |-> req.channel[1:0] == st_reg.slot) // RQ15
        else $error("Group channel does not follow the slot.");
    a_result_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req && we_i && hit_res[0] && !res.done |=> $stable(st_reg.result[0])) // RQ18
        else $error("Result register changed on a bus write.");
endmodule // adc_sequence_control

`default_nettype wire

// [pkg/converter_defs.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the converter sequencer.
// Assumes: Wishbone byte addresses with one 32-bit word per register.
// Notes: Only definitions live here.
`ifndef CONVERTER_DEFS_SVH
`define CONVERTER_DEFS_SVH

`define CTL_OFFSET 16'h1030
`define RES1_OFFSET 16'h1031
`define RES2_OFFSET 16'h1032
`define RES3_OFFSET 16'h1033
`define RES4_OFFSET 16'h1034
`define ADDR_SCALE 2
`define CTL_FLAG_BIT 7
`define CTL_ZERO_BIT 6
`define CTL_SCAN_BIT 5
`define CTL_GROUP_BIT 4
`define CTL_WRITE_MASK 8'h3f
`define CTL_RESET 8'h00
`define SAR_STEPS 8
`define CONV_CYCLES 32
`define SAMPLE_CYCLES 8
`define CHAN_GROUP_REF 2'h3

`endif

// [pkg/converter_pkg.sv]
// Purpose: Types shared by the converter sequencer and its approximation engine.
// Assumes: Nothing beyond the defs header.
// Notes: Constants stay in the defs header; this package holds types only.
package converter_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_START,
        SEQ_CONVERT,
        SEQ_HOLD
    } seq_state_e;

    typedef struct packed {
        logic [3:0] channel;
        logic       start;
        logic       abort;
    } conv_req_s;

    typedef struct packed {
        logic [7:0] value;
        logic       done;
    } conv_res_s;

endpackage

// [verilog/sar_engine.sv]
// Purpose: Runs one eight-step successive approximation on a requested channel.
// Assumes: The comparator answer comp_i is valid in each step's decision cycle.
// Notes: A conversion spans a fixed cycle count; abort drops it without a result.
`include "converter_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module sar_engine #(
    parameter int CONV_CYCLES = `CONV_CYCLES,
    parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Request and answer
    input wire converter_pkg::conv_req_s req_i,
    output converter_pkg::conv_res_s res_o,
    // Analog front end
    input wire logic comp_i,
    output logic [3:0] mux_sel_o,
    output logic sample_o,
    output logic [7:0] dac_o
);
    localparam int STEP_CYCLES = (CONV_CYCLES - SAMPLE_CYCLES) / `SAR_STEPS;

    typedef struct packed {
        logic       busy;
        logic [5:0] cnt;
        logic [2:0] bit_idx;
        logic [7:0] sar;
        logic [3:0] chan;
        logic [7:0] value;
        logic       done;
    } sar_state_s;

    sar_state_s st_reg;
    sar_state_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (req_i.abort) begin
            st_next.busy = 1'b0;
        end else if (req_i.start) begin
            st_next.busy = 1'b1;
            st_next.cnt = 6'h00;
            st_next.bit_idx = 3'h7;
            st_next.sar = 8'h80;
            st_next.chan = req_i.channel;
        end else if (st_reg.busy) begin
            st_next.cnt = st_reg.cnt + 6'h01;
            // Each step tests one bit from the top down, then tries the next.
            if (st_reg.cnt >= 6'(SAMPLE_CYCLES) &&
                st_reg.cnt - 6'(SAMPLE_CYCLES) == 6'(STEP_CYCLES * (7 - st_reg.bit_idx) + STEP_CYCLES - 1)) begin
                st_next.sar[st_reg.bit_idx] = comp_i;
                if (st_reg.bit_idx == 3'h0) begin
                    st_next.busy = 1'b0;
                    st_next.done = 1'b1;
                    st_next.value = {st_reg.sar[7:1], comp_i};
                end else begin
                    st_next.bit_idx = st_reg.bit_idx - 3'h1;
                    st_next.sar[st_reg.bit_idx - 3'h1] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign res_o.value = st_reg.value;
    assign res_o.done = st_reg.done;
    assign mux_sel_o = st_reg.chan;
    assign sample_o = st_reg.busy && st_reg.cnt < 6'(SAMPLE_CYCLES);
    assign dac_o = st_reg.sar;

    a_conv_length: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.start && !req_i.abort ##1 (!req_i.start && !req_i.abort) [*8]
        |-> !st_reg.done)
        else $error("Conversion finished too early.");
endmodule // sar_engine

`default_nettype wire

// [testbench/adc_sequence_control_tb.sv]
// Purpose: Self-checking bench for the converter sequencer, driving its bus and comparator ports.
// Assumes: The comparator answers high while the channel level is at or above the trial value.
// Notes: Each channel holds a distinct level, so every result shows which channel filled it.
`include "converter_defs.svh"
`timescale 1ns/100ps
`default_nettype none

`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module adc_sequence_control_tb;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, low_power_i, comp_i, ack_o, err_o, sample_o, busy_o;
    logic [15:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic [3:0] mux_sel_o;
    logic [1:0] ref_sel_o;
    logic [7:0] dac_o, rd;
    logic [7:0] vin [16];
    logic bus_err;
    int n_mismatch = 0;
    int comparisons = 0;
    localparam logic [15:0] CTL_ADR = 16'(`CTL_OFFSET << `ADDR_SCALE);

    adc_sequence_control #(.CONV_CYCLES(`CONV_CYCLES)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .err_o(err_o), .low_power_i(low_power_i), .comp_i(comp_i), .mux_sel_o(mux_sel_o),
        .ref_sel_o(ref_sel_o), .sample_o(sample_o), .dac_o(dac_o), .busy_o(busy_o));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // The comparator answers one cycle late, which still lands inside each three-cycle step.
    always @(posedge clk_i) begin
        comp_i <= (vin[mux_sel_o] >= dac_o);
    end

    function automatic logic [1:0] exp_ref(input logic [3:0] ch);
        case (ch)
            4'hc: return 2'h1;
            4'hd: return 2'h2;
            4'he: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction

    always @(posedge clk_i) begin
        if (!rst_i && busy_o) begin
            `CHECK(ref_sel_o, exp_ref(mux_sel_o));
        end
    end

    function automatic logic [15:0] res_adr(input int k);
        return 16'((`RES1_OFFSET + k) << `ADDR_SCALE);
    endfunction

    task automatic bus(input logic we, input logic [15:0] adr, input logic [7:0] wd);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= adr;
        dat_i <= {24'h0, wd};
        sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 100);
        rd = dat_o[7:0];
        bus_err = err_o;
        if (n >= 100) begin
            n_mismatch++;
            $display("mismatch at %0t: bus cycle never answered", $time);
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic read_chk(input logic [15:0] adr, input logic [7:0] exp);
        bus(1'b0, adr, 8'h00);
        `CHECK(rd, exp);
    endtask

    task automatic chk_res(input int a, input int b, input int c, input int d);
        read_chk(res_adr(0), vin[a]);
        read_chk(res_adr(1), vin[b]);
        read_chk(res_adr(2), vin[c]);
        read_chk(res_adr(3), vin[d]);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_o !== 1'b0 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 1000) begin
            n_mismatch++;
            $display("mismatch at %0t: sequencer never went idle", $time);
        end
    endtask

    task automatic t_reset();
        read_chk(CTL_ADR, 8'h00);
        bus(1'b0, 16'h40d4, 8'h00);
        `CHECK(bus_err, 1'b1);
        bus(1'b1, CTL_ADR, 8'hff);
        read_chk(CTL_ADR, 8'h3f);
        $display("test reset and access done");
    endtask

    task automatic t_continuous();
        int n;
        bus(1'b1, CTL_ADR, 8'h30);
        n = 0;
        do begin
            bus(1'b0, CTL_ADR, 8'h00);
            n++;
        end while (rd[7] !== 1'b1 && n < 80);
        `CHECK(rd, 8'hb0);
        // Results are read only once the flag says the pass is complete.
        chk_res(0, 1, 2, 3);
        vin[0] = 8'h99;
        vin[2] = 8'h3c;
        // A conversion already under way keeps old charge, so wait past one full pass plus one conversion.
        repeat (200) @(posedge clk_i);
        chk_res(0, 1, 2, 3);
        read_chk(CTL_ADR, 8'hb0);
        `CHECK(busy_o, 1'b1);
        $display("test continuous done");
    endtask

    task automatic t_abort();
        bus(1'b1, CTL_ADR, 8'h05);
        repeat (2) @(posedge clk_i);
        `CHECK(mux_sel_o, 4'h5);
        `CHECK(sample_o, 1'b1);
        read_chk(CTL_ADR, 8'h05);
        wait_idle();
        repeat (50) @(posedge clk_i);
        `CHECK(busy_o, 1'b0);
        read_chk(CTL_ADR, 8'h85);
        chk_res(5, 5, 5, 5);
        $display("test abort and single channel done");
    endtask

    task automatic t_group();
        logic [7:0] cfg [4];
        int base;
        cfg = '{8'h13, 8'h17, 8'h1a, 8'h1e};
        for (int i = 0; i < 4; i++) begin
            base = 4 * i;
            bus(1'b1, CTL_ADR, cfg[i]);
            wait_idle();
            `CHECK(busy_o, 1'b0);
            read_chk(CTL_ADR, cfg[i] | 8'h80);
            chk_res(base, base + 1, base + 2, base + 3);
        end
        $display("test group one-shot done");
    endtask

    task automatic t_result_ro();
        bus(1'b1, res_adr(0), 8'hda);
        read_chk(res_adr(0), vin[12]);
        read_chk(CTL_ADR, 8'h9e);
        $display("test read-only results done");
    endtask

    // Models a wait exit; a stop exit without start-up delay would need a settling pause first.
    task automatic t_low_power();
        bus(1'b1, CTL_ADR, 8'h10);
        repeat (40) @(posedge clk_i);
        low_power_i <= 1'b1;
        // Longer than a whole pass, so a sequencer that ignores the mode would finish here.
        repeat (300) @(posedge clk_i);
        read_chk(CTL_ADR, 8'h10);
        low_power_i <= 1'b0;
        @(posedge clk_i);
        wait_idle();
        read_chk(CTL_ADR, 8'h90);
        chk_res(0, 1, 2, 3);
        $display("test low power suspend done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 16'h0000;
        sel_i = 4'h0;
        dat_i = 32'h0;
        low_power_i = 1'b0;
        comp_i = 1'b0;
        for (int i = 0; i < 16; i++) begin
            vin[i] = 8'(16 * i + 5);
        end
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_continuous();
        t_abort();
        t_group();
        t_result_ro();
        t_low_power();
        tally_and_finish();
    end
endmodule // adc_sequence_control_tb

`default_nettype wire
